/* verilog/ccrs_core_regs.sv */
`timescale 1ns/1ns
`include "ccrs_defines.svh"
module ccrs_core_regs (
	input  wire logic        CLK,
	input  wire logic        SRST,
	// Vector word returned by memory during the reset fetch.
	input  wire logic        FETCH_VALID,
	input  wire logic [31:0] FETCH_DATA,
	// Register file ports: index 0 to 15, index 13 is the active stack.
	input  wire logic [3:0]  RD_A_ADDR,
	input  wire logic [3:0]  RD_B_ADDR,
	input  wire logic        WR_EN,
	input  wire logic [3:0]  WR_ADDR,
	input  wire logic [31:0] WR_DATA,
	// Push request: active stack drops by four.
	input  wire logic        PUSH,
	// Program counter update from the datapath.
	input  wire logic        PC_LOAD,
	input  wire logic [31:0] PC_NEXT,
	input  wire logic        EXEC_T_LOAD,
	input  wire logic        EXEC_T_IN,
	// Flags produced by executed instructions (N Z C V).
	input  wire logic        FLAGS_LOAD,
	input  wire logic [3:0]  FLAGS_IN,
	// Exception entry and final return.
	input  wire logic        EXC_ENTER,
	input  wire logic [5:0]  EXC_NUM_IN,
	input  wire logic        EXC_RETURN_ALL,
	// Special register moves.
	input  wire logic        SPEC_WR,
	input  wire logic [3:0]  SPEC_SEL,
	input  wire logic [31:0] SPEC_WDATA,
	output logic      [31:0] SPEC_RDATA,
	output logic      [31:0] RD_A_DATA,
	output logic      [31:0] RD_B_DATA,
	output logic      [31:0] FETCH_ADDR,
	output logic             FETCH_REQ,
	output logic             CORE_RUN,
	output logic             HANDLER_MODE,
	output logic      [31:0] PROGRAM_COUNTER,
	output logic      [31:0] ACTIVE_STACK_REG,
	output logic             BLOCK_CONFIG_EXC
);
	import ccrs_pkg::*;

	ccrs_state_s st;      // Registered state.
	ccrs_state_s next_st; // Next state.
	logic [31:0] mem_a;   // Array read data, port A.
	logic [31:0] mem_b;   // Array read data, port B.
	logic [3:0]  rd_a_q;  // Address that produced mem_a.
	logic [3:0]  rd_b_q;  // Address that produced mem_b.
	logic        gpr_we;  // Array write enable.
	logic        use_proc;// Active stack is the process pointer.
	logic [31:0] active_sp;
	logic [31:0] status_word;

	// Only the array holds indices 0-12 and 14; 13 and 15 live in the struct.
	assign gpr_we = WR_EN && (WR_ADDR != 4'hD) && (WR_ADDR != 4'hF) && (st.phase == CCRS_RUN);

	// General registers and link register share one memory.
	// Plain data storage
	ccrs_gpr_mem #(.WIDTH(32), .DEPTH(16)) u_gpr (
		.CLK     (CLK),
		.we      (gpr_we),
		.waddr   (WR_ADDR),
		.wdata   (WR_DATA),
		.raddr_a (RD_A_ADDR),
		.raddr_b (RD_B_ADDR),
		.rdata_a (mem_a),
		.rdata_b (mem_b)
	);

	// Remember read addresses so the late mux matches the memory latency.
	always_ff @(posedge CLK) begin
		rd_a_q <= RD_A_ADDR;
		rd_b_q <= RD_B_ADDR;
	end

	// Stack choice; Handler mode overrides the select bit.
	// Handler forces main
	assign use_proc  = !st.handler && st.stack_sel;
	assign active_sp = use_proc ? st.proc_sp : st.main_sp;

	// Full status word assembled from three disjoint fields.
	// Disjoint status fields
	assign status_word = {st.flags, 3'h0, st.exec_t, 18'h0, st.exc_num};

	// Register-stage selection for a general read port.
	function automatic logic [31:0] pick(input logic [3:0] a, input logic [31:0] m,
		input logic [31:0] sp, input logic [31:0] pc);
		logic [31:0] r;
		r = m;
		if (a == 4'hD) begin
			r = sp;
		end else if (a == 4'hF) begin
			r = pc;
		end
		return r;
	endfunction : pick

	// Next-state logic for the whole state struct.
	always_comb begin
		next_st = st;
		next_st.fetch_req = 1'b0;
		case (st.phase)
			// Reset fetch of the initial main stack pointer.
			// Load main pointer
			CCRS_FETCH_SP: begin
				next_st.fetch_addr = `CCRS_VEC_SP_ADDR;
				next_st.fetch_req  = 1'b1;
				if (FETCH_VALID && st.fetch_req) begin
					next_st.main_sp    = FETCH_DATA;
					next_st.phase      = CCRS_FETCH_PC;
					next_st.fetch_addr = `CCRS_VEC_PC_ADDR;
				end
			end
			// Reset fetch of the reset vector.
			// Load program counter
			CCRS_FETCH_PC: begin
				next_st.fetch_addr = `CCRS_VEC_PC_ADDR;
				next_st.fetch_req  = 1'b1;
				if (FETCH_VALID && st.fetch_req) begin
					next_st.pc        = FETCH_DATA;
					next_st.exec_t    = FETCH_DATA[0];
					next_st.phase     = CCRS_RUN;
					next_st.fetch_req = 1'b0;
				end
			end
			// Normal execution.
			CCRS_RUN: begin
				if (FLAGS_LOAD) begin
					next_st.flags = FLAGS_IN;
				end
				if (PC_LOAD) begin
					next_st.pc = PC_NEXT;
				end
				if (EXEC_T_LOAD) begin
					next_st.exec_t = EXEC_T_IN;
				end
				// Writes to index 13 land in whichever pointer is active.
				// Independent pointers
				if (WR_EN && WR_ADDR == 4'hD) begin
					if (use_proc) next_st.proc_sp = WR_DATA;
					else next_st.main_sp = WR_DATA;
				end
				if (WR_EN && WR_ADDR == 4'hF) begin
					next_st.pc = WR_DATA;
				end
				// Push: decrement first; the datapath stores at the new value.
				// Full descending push
				if (PUSH) begin
					if (use_proc) next_st.proc_sp = active_sp - 32'h00000004;
					else next_st.main_sp = active_sp - 32'h00000004;
				end
				// Special register writes; exception number never taken.
				// Writable combinations
				if (SPEC_WR) begin
					case (SPEC_SEL)
						`CCRS_SEL_FLAGS, `CCRS_SEL_FLAGS_EXC, `CCRS_SEL_FLAGS_EXEC,
						`CCRS_SEL_ALL: begin
							next_st.flags = SPEC_WDATA[`CCRS_FLAG_N:`CCRS_FLAG_V];
						end
						`CCRS_SEL_MAIN_SP: begin
							next_st.main_sp = SPEC_WDATA;
						end
						`CCRS_SEL_PROC_SP: begin
							next_st.proc_sp = SPEC_WDATA;
						end
						`CCRS_SEL_MASK: begin
							next_st.mask = SPEC_WDATA[`CCRS_MASK_BIT];
						end
						`CCRS_SEL_CTRL: begin
							if (!st.handler) begin
								next_st.stack_sel = SPEC_WDATA[`CCRS_STACK_SEL_BIT];
							end
						end
						default: begin
							// Read-only views and unused codes take no write.
						end
					endcase
				end
				// Mode changes: entry wins over return in the same cycle.
				// Handler mode tracking
				if (EXC_ENTER) begin
					next_st.handler = 1'b1;
					next_st.exc_num = EXC_NUM_IN;
				end else if (EXC_RETURN_ALL) begin
					next_st.handler = 1'b0;
					next_st.exc_num = `CCRS_EXC_RESET;
				end
			end
			default: begin
				next_st.phase = CCRS_FETCH_SP;
			end
		endcase
		// Registered read data for special moves; execution bits read zero.
		case (SPEC_SEL)
			`CCRS_SEL_FLAGS:      next_st.rd_data = {st.flags, 28'h0};
			`CCRS_SEL_EXC:        next_st.rd_data = {26'h0, st.exc_num};
			`CCRS_SEL_EXEC:       next_st.rd_data = 32'h00000000;
			`CCRS_SEL_FLAGS_EXC:  next_st.rd_data = {st.flags, 22'h0, st.exc_num};
			`CCRS_SEL_FLAGS_EXEC: next_st.rd_data = {st.flags, 28'h0};
			`CCRS_SEL_EXC_EXEC:   next_st.rd_data = {26'h0, st.exc_num};
			`CCRS_SEL_ALL:        next_st.rd_data = {st.flags, 22'h0, st.exc_num};
			`CCRS_SEL_MAIN_SP:    next_st.rd_data = st.main_sp;
			`CCRS_SEL_PROC_SP:    next_st.rd_data = st.proc_sp;
			`CCRS_SEL_MASK:       next_st.rd_data = {31'h0, st.mask};
			// Select bit reads zero in Handler mode.
			`CCRS_SEL_CTRL:       next_st.rd_data = {30'h0, st.stack_sel && !st.handler, 1'b0};
			default:              next_st.rd_data = 32'h00000000;
		endcase
		// Mask blocks every exception except the fixed-priority ones.
		// Priority mask
		next_st.block_cfg = st.mask;
		// Register-file reads; 13 and 15 come from the struct.
		next_st.rd_a = pick(RD_A_ADDR, 32'h0, active_sp, st.pc);
		next_st.rd_b = pick(RD_B_ADDR, 32'h0, active_sp, st.pc);
		// Synchronous reset: every field of the state struct is given a value.
		// Thread after reset
		if (SRST) begin
			next_st.phase     = CCRS_FETCH_SP;
			next_st.handler   = 1'b0;
			next_st.exc_num   = `CCRS_EXC_RESET;
			next_st.mask      = `CCRS_MASK_RESET;
			next_st.stack_sel = `CCRS_SEL_RESET;
			next_st.fetch_req = 1'b0;
			next_st.fetch_addr = `CCRS_VEC_SP_ADDR;
			next_st.rd_data   = 32'h00000000;
			next_st.rd_a      = 32'h00000000;
			next_st.rd_b      = 32'h00000000;
			next_st.block_cfg = 1'b0;
			next_st.pc        = 32'h00000000;
			next_st.main_sp   = 32'h00000000;
			next_st.proc_sp   = 32'h00000000;
			next_st.flags     = 4'h0;
			next_st.exec_t    = 1'b0;
		end
	end

	// State register.
	always_ff @(posedge CLK) begin
		st <= next_st;
	end

	// Outputs straight from flops except ACTIVE_STACK_REG and CORE_RUN; array reads go through the late mux.
	// The array word is itself a flop, so selection is a single mux level.
	assign RD_A_DATA        = (rd_a_q == 4'hD || rd_a_q == 4'hF) ? st.rd_a : mem_a;
	assign RD_B_DATA        = (rd_b_q == 4'hD || rd_b_q == 4'hF) ? st.rd_b : mem_b;
	assign SPEC_RDATA       = st.rd_data;
	assign FETCH_ADDR       = st.fetch_addr;
	assign FETCH_REQ        = st.fetch_req;
	assign CORE_RUN         = (st.phase == CCRS_RUN);
	assign HANDLER_MODE     = st.handler;
	assign PROGRAM_COUNTER  = st.pc;
	assign ACTIVE_STACK_REG = active_sp;
	assign BLOCK_CONFIG_EXC = st.block_cfg;

	// Reset leaves the core in Thread mode.
	thread_after_reset_a : assert property (@(posedge CLK) $past(SRST) |-> !HANDLER_MODE)
		else $error("not in thread mode after reset");
	// Return only on the final return signal.
	handler_hold_a : assert property (@(posedge CLK) disable iff (SRST)
		HANDLER_MODE && !EXC_RETURN_ALL |=> HANDLER_MODE)
		else $error("left handler mode early");
	// Push decrements the active pointer by four.
	push_decrement_a : assert property (@(posedge CLK) disable iff (SRST)
		CORE_RUN && PUSH && !WR_EN && !SPEC_WR && !EXC_ENTER && !EXC_RETURN_ALL
		|=> ACTIVE_STACK_REG == $past(ACTIVE_STACK_REG) - 32'h00000004)
		else $error("push did not decrement stack");
	// Handler mode uses the main pointer.
	handler_main_sp_a : assert property (@(posedge CLK) disable iff (SRST)
		HANDLER_MODE |-> ACTIVE_STACK_REG == st.main_sp)
		else $error("handler not on main stack");
	// Reset fetches address zero then four.
	vector_order_a : assert property (@(posedge CLK) disable iff (SRST)
		FETCH_REQ && FETCH_VALID && st.phase == CCRS_FETCH_SP
		|=> FETCH_ADDR == `CCRS_VEC_PC_ADDR)
		else $error("vector fetch order wrong");
	// Program counter and execution bit come from the vector.
	reset_vector_a : assert property (@(posedge CLK) disable iff (SRST)
		FETCH_REQ && FETCH_VALID && st.phase == CCRS_FETCH_PC
		|=> PROGRAM_COUNTER == $past(FETCH_DATA) && st.exec_t == $past(FETCH_DATA[0]))
		else $error("reset vector not loaded");
	// Status writes keep the exception number.
	exc_keep_a : assert property (@(posedge CLK) disable iff (SRST)
		CORE_RUN && SPEC_WR && !EXC_ENTER && !EXC_RETURN_ALL |=> $stable(st.exc_num))
		else $error("exception number changed by write");
	// Execution view reads zero.
	exec_read_zero_a : assert property (@(posedge CLK) disable iff (SRST)
		SPEC_SEL == `CCRS_SEL_EXEC |=> SPEC_RDATA == 32'h00000000)
		else $error("execution view read nonzero");
	// Mask drives the blocking output.
	mask_block_a : assert property (@(posedge CLK) disable iff (SRST)
		st.mask |=> BLOCK_CONFIG_EXC)
		else $error("mask did not block exceptions");
endmodule : ccrs_core_regs

/* verilog/ccrs_defines.svh */
`ifndef CCRS_DEFINES_SVH
`define CCRS_DEFINES_SVH
// Vector table addresses fetched during reset.
`define CCRS_VEC_SP_ADDR     32'h00000000
`define CCRS_VEC_PC_ADDR     32'h00000004
// Status word field positions, then the stack select and mask bits.
`define CCRS_FLAG_N          31
`define CCRS_FLAG_Z          30
`define CCRS_FLAG_C          29
`define CCRS_FLAG_V          28
`define CCRS_EXEC_T          24
`define CCRS_EXC_HI          5
`define CCRS_STACK_SEL_BIT   1
`define CCRS_MASK_BIT        0
// Reset values of the masked registers.
`define CCRS_EXC_RESET       6'h00
`define CCRS_MASK_RESET      1'h0
`define CCRS_SEL_RESET       1'h0
// Special register selector codes.
`define CCRS_SEL_FLAGS       4'h0
`define CCRS_SEL_EXC         4'h1
`define CCRS_SEL_EXEC        4'h2
`define CCRS_SEL_FLAGS_EXC   4'h3
`define CCRS_SEL_FLAGS_EXEC  4'h4
`define CCRS_SEL_EXC_EXEC    4'h5
`define CCRS_SEL_ALL         4'h6
`define CCRS_SEL_MAIN_SP     4'h8
`define CCRS_SEL_PROC_SP     4'h9
`define CCRS_SEL_MASK        4'h0A
`define CCRS_SEL_CTRL        4'h0B
// Exception numbers with a fixed priority; others are configurable.
`define CCRS_EXC_NMI         6'h02
`define CCRS_EXC_HARDFAULT   6'h03
`endif

/* verilog/ccrs_pkg.sv */
package ccrs_pkg;
	// Reset sequence steps.
	typedef enum logic [1:0] {
		CCRS_FETCH_SP,
		CCRS_FETCH_PC,
		CCRS_RUN
	} ccrs_phase_e;
	// Whole state of the register block apart from the array and the read-address flops.
	typedef struct packed {
		ccrs_phase_e phase;
		logic        handler;
		logic [5:0]  exc_num;
		logic [3:0]  flags;
		logic        exec_t;
		logic        mask;
		logic        stack_sel;
		logic [31:0] main_sp;
		logic [31:0] proc_sp;
		logic [31:0] pc;
		logic [31:0] rd_data;
		logic [31:0] rd_a;
		logic [31:0] rd_b;
		logic [31:0] fetch_addr;
		logic        fetch_req;
		logic        block_cfg;
	} ccrs_state_s;
endpackage : ccrs_pkg

/* verilog/ccrs_gpr_mem.sv */
`timescale 1ns/1ns
// Register array for general registers 0 to 12 and 14, two read ports.
// Contents are not reset: their reset value is undefined by design.
module ccrs_gpr_mem #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	input  wire logic                     CLK,
	input  wire logic                     we,
	input  wire logic [$clog2(DEPTH)-1:0] waddr,
	input  wire logic [WIDTH-1:0]         wdata,
	input  wire logic [$clog2(DEPTH)-1:0] raddr_a,
	input  wire logic [$clog2(DEPTH)-1:0] raddr_b,
	output logic      [WIDTH-1:0]         rdata_a,
	output logic      [WIDTH-1:0]         rdata_b
);
	// Storage words.
	logic [WIDTH-1:0] mem [DEPTH];

	// One write and two registered reads per cycle; a read sees old data.
	always_ff @(posedge CLK) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata_a <= mem[raddr_a];
		rdata_b <= mem[raddr_b];
	end
endmodule : ccrs_gpr_mem

/* verif/ccrs_testbench.sv */
`timescale 1ns/1ns
module testbench;
	import ccrs_pkg::*;
	// Single-bit stimulus driven on the falling edge.
	logic        CLK, SRST, FETCH_VALID, WR_EN, PUSH, PC_LOAD;
	logic        EXEC_T_LOAD, EXEC_T_IN, FLAGS_LOAD, EXC_ENTER, EXC_RETURN_ALL, SPEC_WR;
	// Multi-bit stimulus.
	logic [3:0]  RD_A_ADDR, RD_B_ADDR, WR_ADDR, FLAGS_IN, SPEC_SEL;
	logic [5:0]  EXC_NUM_IN;
	logic [31:0] FETCH_DATA, WR_DATA, PC_NEXT, SPEC_WDATA;
	// Outputs of the block.
	logic [31:0] SPEC_RDATA, RD_A_DATA, RD_B_DATA, FETCH_ADDR, PROGRAM_COUNTER;
	logic [31:0] ACTIVE_STACK_REG;
	logic        FETCH_REQ, CORE_RUN, HANDLER_MODE, BLOCK_CONFIG_EXC;
	// Bookkeeping of the self-check.
	int          fails, checks, cyc;
	// Boot image: stack top and a vector with its low bit set.
	localparam logic [31:0] SP0 = 32'h20000400;
	localparam logic [31:0] RV  = 32'h000000C1;

	ccrs_core_regs ccrs_core_regs_inst (
		.CLK(CLK), .SRST(SRST), .FETCH_VALID(FETCH_VALID), .FETCH_DATA(FETCH_DATA),
		.RD_A_ADDR(RD_A_ADDR), .RD_B_ADDR(RD_B_ADDR), .WR_EN(WR_EN), .WR_ADDR(WR_ADDR),
		.WR_DATA(WR_DATA), .PUSH(PUSH), .PC_LOAD(PC_LOAD), .PC_NEXT(PC_NEXT),
		.EXEC_T_LOAD(EXEC_T_LOAD), .EXEC_T_IN(EXEC_T_IN), .FLAGS_LOAD(FLAGS_LOAD),
		.FLAGS_IN(FLAGS_IN), .EXC_ENTER(EXC_ENTER), .EXC_NUM_IN(EXC_NUM_IN),
		.EXC_RETURN_ALL(EXC_RETURN_ALL), .SPEC_WR(SPEC_WR), .SPEC_SEL(SPEC_SEL),
		.SPEC_WDATA(SPEC_WDATA), .SPEC_RDATA(SPEC_RDATA), .RD_A_DATA(RD_A_DATA),
		.RD_B_DATA(RD_B_DATA), .FETCH_ADDR(FETCH_ADDR), .FETCH_REQ(FETCH_REQ),
		.CORE_RUN(CORE_RUN), .HANDLER_MODE(HANDLER_MODE),
		.PROGRAM_COUNTER(PROGRAM_COUNTER), .ACTIVE_STACK_REG(ACTIVE_STACK_REG),
		.BLOCK_CONFIG_EXC(BLOCK_CONFIG_EXC)
	);

	// A 50 ns clock period.
	initial begin
		CLK = 1'b0;
		forever #25 CLK = ~CLK;
	end

	// Prints the counts and the verdict, then stops the run.
	task automatic close_out();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : close_out

	// A hang is cut short well beyond the fewer than a hundred cycles the tests need.
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 2000) begin
			fails++;
			close_out();
		end
	end

	// Compares one value and reports a mismatch at once.
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// One special register move into the block, held for one edge.
	// An idle edge follows, so a second call never re-raises the strobe at once.
	task automatic spw(input logic [3:0] s, input logic [31:0] d);
		SPEC_WR = 1'b1;
		SPEC_SEL = s;
		SPEC_WDATA = d;
		@(negedge CLK);
		SPEC_WR = 1'b0;
		@(negedge CLK);
	endtask : spw

	// A special register read; the data is registered, so look one edge later.
	task automatic spr(input logic [3:0] s, input logic [31:0] e, input string nm);
		SPEC_SEL = s;
		@(negedge CLK);
		chk(nm, SPEC_RDATA, e);
	endtask : spr

	// General register write of one full word.
	// An idle edge follows, so back-to-back calls keep a clean strobe.
	task automatic gw(input logic [3:0] a, input logic [31:0] d);
		WR_EN = 1'b1;
		WR_ADDR = a;
		WR_DATA = d;
		@(negedge CLK);
		WR_EN = 1'b0;
		@(negedge CLK);
	endtask : gw

	// Reads through both ports at once.
	task automatic gr(input logic [3:0] a, input logic [3:0] b, input logic [31:0] ea,
			input logic [31:0] eb);
		RD_A_ADDR = a;
		RD_B_ADDR = b;
		@(negedge CLK);
		chk("read a", RD_A_DATA, ea);
		chk("read b", RD_B_DATA, eb);
	endtask : gr

	// Raises a single-cycle strobe through a flag reference.
	task automatic pulse(ref logic s);
		s = 1'b1;
		@(negedge CLK);
		s = 1'b0;
	endtask : pulse

	// Main sequence: boot, status views, stacks, exceptions, general registers.
	initial begin
		{SRST, FETCH_VALID, WR_EN, PUSH, PC_LOAD, EXEC_T_LOAD, EXEC_T_IN} = 7'h7F & 7'h40;
		{FLAGS_LOAD, EXC_ENTER, EXC_RETURN_ALL, SPEC_WR} = 4'h0;
		{RD_A_ADDR, RD_B_ADDR, WR_ADDR, FLAGS_IN, SPEC_SEL} = 20'h00000;
		EXC_NUM_IN = 6'h00;
		{FETCH_DATA, WR_DATA, PC_NEXT, SPEC_WDATA} = 128'h0;
		fails = 0;
		checks = 0;
		cyc = 0;
		repeat (8) @(negedge CLK);
		chk("handler in reset", HANDLER_MODE, 32'h0);
		chk("fetch in reset", FETCH_REQ, 32'h0);
		SRST = 1'b0;
		@(negedge CLK);
		chk("fetch req", FETCH_REQ, 32'h1);
		chk("fetch addr sp", FETCH_ADDR, 32'h00000000);
		FETCH_VALID = 1'b1;
		FETCH_DATA = SP0;
		@(negedge CLK);
		chk("fetch addr pc", FETCH_ADDR, 32'h00000004);
		FETCH_DATA = RV;
		@(negedge CLK);
		FETCH_VALID = 1'b0;
		FETCH_DATA = ~RV;
		chk("pc from vector", PROGRAM_COUNTER, RV);
		chk("sp from vector", ACTIVE_STACK_REG, SP0);
		chk("run", CORE_RUN, 32'h1);
		chk("thread", HANDLER_MODE, 32'h0);
		spr(4'hB, 32'h0, "select reset");
		spr(4'hA, 32'h0, "mask reset");
		spr(4'h1, 32'h0, "exc reset");
		spr(4'h2, 32'h0, "exec reads zero");
		FLAGS_IN = 4'hA;
		pulse(FLAGS_LOAD);
		spr(4'h0, 32'hA0000000, "flags");
		spr(4'h3, 32'hA0000000, "flags exc");
		spw(4'h6, 32'h5100003F);
		spr(4'h6, 32'h50000000, "all view");
		spw(4'h5, 32'hF0000000);
		spr(4'h0, 32'h50000000, "exc exec ro");
		spw(4'h4, 32'h31000000);
		spr(4'h4, 32'h30000000, "flags exec");
		spw(4'h3, 32'h9000003F);
		spr(4'h0, 32'h90000000, "flags exc rw");
		EXEC_T_IN = 1'b1;
		pulse(EXEC_T_LOAD);
		spr(4'h2, 32'h0, "exec after load");
		spw(4'h8, 32'h20000800);
		spw(4'h9, 32'h10000100);
		spr(4'h8, 32'h20000800, "main sp");
		spr(4'h9, 32'h10000100, "proc sp");
		chk("active main", ACTIVE_STACK_REG, 32'h20000800);
		spw(4'hB, 32'h00000002);
		chk("active proc", ACTIVE_STACK_REG, 32'h10000100);
		pulse(PUSH);
		chk("push", ACTIVE_STACK_REG, 32'h100000FC);
		spr(4'h8, 32'h20000800, "main kept");
		gr(4'hD, 4'hF, 32'h100000FC, RV);
		EXC_NUM_IN = 6'h0F;
		pulse(EXC_ENTER);
		chk("handler", HANDLER_MODE, 32'h1);
		chk("handler sp", ACTIVE_STACK_REG, 32'h20000800);
		spr(4'h1, 32'h0000000F, "exc num");
		spr(4'hB, 32'h0, "select hidden");
		spw(4'hB, 32'h0);
		spw(4'hA, 32'h1);
		spr(4'hA, 32'h1, "mask set");
		chk("block", BLOCK_CONFIG_EXC, 32'h1);
		EXC_NUM_IN = 6'h2F;
		pulse(EXC_ENTER);
		spr(4'h1, 32'h0000002F, "nested exc");
		pulse(EXC_RETURN_ALL);
		chk("back thread", HANDLER_MODE, 32'h0);
		chk("select kept", ACTIVE_STACK_REG, 32'h100000FC);
		spr(4'h1, 32'h0, "exc cleared");
		spw(4'hA, 32'h0);
		spr(4'hA, 32'h0, "mask clear");
		chk("unblock", BLOCK_CONFIG_EXC, 32'h0);
		gw(4'h0, 32'h12345678);
		gw(4'hC, 32'h89ABCDEF);
		gw(4'hE, 32'h00000F01);
		gr(4'h0, 4'hC, 32'h12345678, 32'h89ABCDEF);
		gr(4'hE, 4'h0, 32'h00000F01, 32'h12345678);
		PC_NEXT = 32'h00000200;
		pulse(PC_LOAD);
		gr(4'hF, 4'hE, 32'h00000200, 32'h00000F01);
		close_out();
	end
endmodule : testbench
